//--- core/rdsw_core.sv
// rx descriptor walker, buffer writer and status writeback engine
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "rdsw_defines.svh"

module rdsw_core #(
  parameter int BLEN_W = 11,
  parameter int MISS_W = 16
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input rdsw_pkg::rdsw_regreq_t regReq,
  output logic [31:0] regRdata,
  output rdsw_pkg::rdsw_memreq_t memOut,
  input wire logic memAck,
  input wire logic [31:0] memRdata,
  input wire logic rxValid,
  input wire logic [31:0] rxData,
  input wire logic rxLast,
  input rdsw_pkg::rdsw_rxstat_t rxStat,
  output logic rxReady,
  output logic [31:0] txListBase
);
  import rdsw_pkg::*;

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  if (BLEN_W != `RDSW_BLEN_HI + 1) begin : gBlenCheck
    $error("BLEN_W must match the buffer length field");
  end
  if (MISS_W < 1 || MISS_W > 32) begin : gMissCheck
    $error("MISS_W must be 1 to 32");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    rdsw_state_t state;
    rdsw_state_t retState;
    logic running;
    logic csumEn;
    logic wdogFlag;
    logic [31:0] rxBase;
    logic [31:0] txBase;
    logic [31:0] curDesc;
    logic [31:0] prevDesc;
    logic [31:0] bufAddr;
    logic [31:0] nextPtr;
    logic [BLEN_W-1:0] bufLen;
    logic [11:0] segOff;
    logic [13:0] frameBytes;
    logic inFrame;
    logic curFirst;
    logic prevFirst;
    logic lastWord;
    rdsw_rxstat_t lastStat;
    logic memWrite;
    logic [31:0] memAddr;
    logic [31:0] memWdata;
    logic [MISS_W-1:0] missed;
    logic [31:0] rdData;
  } rdsw_core_regs_t;

  rdsw_core_regs_t r_reg;
  rdsw_core_regs_t r_next;

  // ----------------------------------------
  // descriptor word 0 builder
  // ----------------------------------------
  function automatic logic [31:0] closeWord(input rdsw_close_t kind, input logic first,
                                            input rdsw_rxstat_t st, input logic [13:0] bytes,
                                            input logic csum);
    logic [31:0] w;
    logic isShort;
    logic isLong;
    w = `RDSW_RST_WORD;
    isShort = (st.byteCount < `RDSW_MIN_FRAME) && !st.fifoOverflow;
    isLong = st.byteCount > `RDSW_MAX_FRAME;
    w[`RDSW_BIT_OWN] = 1'b0;
    w[`RDSW_LEN_HI:`RDSW_LEN_LO] = bytes;
    w[`RDSW_BIT_FIRST] = first;
    if (kind == CL_END) begin
      w[`RDSW_LEN_HI:`RDSW_LEN_LO] = st.byteCount;
      w[`RDSW_BIT_LAST] = 1'b1;
      w[`RDSW_BIT_UNMATCH] = st.addrUnmatched;
      w[`RDSW_BIT_MCAST] = st.multicastFlag;
      w[`RDSW_BIT_SHORT] = isShort;
      w[`RDSW_BIT_LONG] = isLong;
      w[`RDSW_BIT_LATECOL] = st.lateCollisionSeen;
      w[`RDSW_BIT_ALIGN] = st.alignmentError;
      w[`RDSW_BIT_CRC] = st.crcError;
      w[`RDSW_BIT_OVF] = st.fifoOverflow;
      w[`RDSW_BIT_ERRSUM] = isShort | isLong | st.lateCollisionSeen | st.crcError |
                            st.fifoOverflow;
      if (csum) begin
        w[`RDSW_BIT_SRC_HI:`RDSW_BIT_SRC_LO] = {st.ipCsumFail, st.l4CsumFail};
        w[`RDSW_BIT_TYPE] = st.ipPkt;
        w[`RDSW_BIT_WDOG_TCP] = st.tcpPkt;
        w[`RDSW_BIT_PHY_UDP] = st.udpPkt;
      end else begin
        w[`RDSW_BIT_SRC_HI:`RDSW_BIT_SRC_LO] = st.loopSource;
        w[`RDSW_BIT_TYPE] = st.ethType;
        w[`RDSW_BIT_WDOG_TCP] = st.watchdogTimeout;
        w[`RDSW_BIT_PHY_UDP] = st.phyError;
      end
    end else if (kind == CL_TRUNC) begin
      w[`RDSW_BIT_LAST] = 1'b1;
      w[`RDSW_BIT_TRUNC] = 1'b1;
      w[`RDSW_BIT_ERRSUM] = 1'b1;
    end
    return w;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic pollHit;
    logic [11:0] offPlus;
    r_next = r_reg;
    pollHit = 1'b0;
    offPlus = r_reg.segOff + `RDSW_WORD_BYTES;
    r_next.rdData = `RDSW_RST_WORD;
    rxReady = 1'b0;
    if (regReq.rd) begin
      case (regReq.addr)
        `RDSW_REG_CTRL: r_next.rdData[`RDSW_CTRL_RUN] = r_reg.running;
        `RDSW_REG_RX_BASE: r_next.rdData = r_reg.rxBase;
        `RDSW_REG_TX_BASE: r_next.rdData = r_reg.txBase;
        `RDSW_REG_INT_STAT: r_next.rdData[`RDSW_INT_WDOG] = r_reg.wdogFlag;
        `RDSW_REG_MISSED: r_next.rdData[MISS_W-1:0] = r_reg.missed;
        `RDSW_REG_CUR_DESC: r_next.rdData = r_reg.curDesc;
        `RDSW_REG_WD_CSUM: r_next.rdData[`RDSW_CSUM_EN] = r_reg.csumEn;
        default: r_next.rdData = `RDSW_RST_WORD;
      endcase
    end
    if (regReq.wr) begin
      case (regReq.addr)
        `RDSW_REG_CTRL: begin
          r_next.running = regReq.wdata[`RDSW_CTRL_RUN];
          pollHit = regReq.wdata[`RDSW_CTRL_POLL];
          if (regReq.wdata[`RDSW_CTRL_RUN] && !r_reg.running) begin
            r_next.curDesc = r_reg.rxBase;
          end
        end
        `RDSW_REG_RX_BASE: r_next.rxBase = regReq.wdata;
        `RDSW_REG_TX_BASE: r_next.txBase = regReq.wdata;
        `RDSW_REG_INT_STAT: begin
          if (regReq.wdata[`RDSW_INT_WDOG]) begin
            r_next.wdogFlag = 1'b0;
          end
        end
        `RDSW_REG_WD_CSUM: r_next.csumEn = regReq.wdata[`RDSW_CSUM_EN];
        default: r_next.running = r_next.running;
      endcase
    end
    case (r_reg.state)
      ST_IDLE: begin
        if (r_reg.running) begin
          r_next.state = ST_RD0;
          r_next.memAddr = r_reg.curDesc;
          r_next.memWrite = 1'b0;
        end else begin
          rxReady = 1'b1;
          if (rxValid) begin
            r_next.missed = r_reg.missed + 1'b1;
            r_next.state = rxLast ? ST_IDLE : ST_DROP;
          end
        end
      end
      ST_RD0: begin
        if (memAck) begin
          if (memRdata[`RDSW_BIT_OWN]) begin
            if (r_reg.inFrame) begin
              r_next.state = ST_CLOSE;
              r_next.retState = ST_RD1;
              r_next.memAddr = r_reg.prevDesc;
              r_next.memWrite = 1'b1;
              r_next.memWdata = closeWord(CL_MID, r_reg.prevFirst, r_reg.lastStat,
                                          r_reg.frameBytes, r_reg.csumEn);
            end else begin
              r_next.state = ST_RD1;
              r_next.memAddr = r_reg.curDesc + `RDSW_OFS_W1;
            end
          end else if (r_reg.inFrame) begin
            r_next.state = ST_CLOSE;
            r_next.retState = ST_DROP;
            r_next.inFrame = 1'b0;
            r_next.frameBytes = 14'h0000;
            r_next.memAddr = r_reg.prevDesc;
            r_next.memWrite = 1'b1;
            r_next.memWdata = closeWord(CL_TRUNC, r_reg.prevFirst, r_reg.lastStat,
                                        r_reg.frameBytes, r_reg.csumEn);
          end else begin
            r_next.state = ST_STALL;
          end
        end
      end
      ST_RD1: begin
        if (memAck) begin
          r_next.bufLen = memRdata[`RDSW_BLEN_HI:0];
          r_next.state = ST_RD2;
          r_next.memAddr = r_reg.curDesc + `RDSW_OFS_W2;
        end
      end
      ST_RD2: begin
        if (memAck) begin
          r_next.bufAddr = memRdata;
          r_next.state = ST_RD3;
          r_next.memAddr = r_reg.curDesc + `RDSW_OFS_W3;
        end
      end
      ST_RD3: begin
        if (memAck) begin
          r_next.nextPtr = memRdata;
          r_next.segOff = 12'h000;
          r_next.curFirst = !r_reg.inFrame;
          r_next.state = ST_DATA;
        end
      end
      ST_DATA: begin
        if (!r_reg.running && !r_reg.inFrame) begin
          r_next.state = ST_IDLE;
        end else begin
          rxReady = 1'b1;
          if (rxValid) begin
            r_next.state = ST_WR;
            r_next.memAddr = r_reg.bufAddr + {20'h00000, r_reg.segOff};
            r_next.memWdata = rxData;
            r_next.memWrite = 1'b1;
            r_next.lastWord = rxLast;
            r_next.lastStat = rxStat;
            r_next.inFrame = 1'b1;
          end
        end
      end
      ST_WR: begin
        if (memAck) begin
          r_next.segOff = offPlus;
          r_next.frameBytes = 14'(r_reg.frameBytes + `RDSW_WORD_BYTES);
          if (r_reg.lastWord) begin
            r_next.state = ST_CLOSE;
            r_next.retState = ST_IDLE;
            r_next.memAddr = r_reg.curDesc;
            r_next.memWdata = closeWord(CL_END, r_reg.curFirst, r_reg.lastStat,
                                        r_reg.frameBytes, r_reg.csumEn);
            r_next.curDesc = r_reg.nextPtr;
            r_next.inFrame = 1'b0;
            r_next.frameBytes = 14'h0000;
            if (!r_reg.csumEn && r_reg.lastStat.watchdogTimeout) begin
              r_next.wdogFlag = 1'b1;
            end
          end else if (offPlus >= {1'b0, r_reg.bufLen}) begin
            r_next.state = ST_RD0;
            r_next.prevDesc = r_reg.curDesc;
            r_next.prevFirst = r_reg.curFirst;
            r_next.curDesc = r_reg.nextPtr;
            r_next.memAddr = r_reg.nextPtr;
            r_next.memWrite = 1'b0;
          end else begin
            r_next.state = ST_DATA;
          end
        end
      end
      ST_CLOSE: begin
        if (memAck) begin
          r_next.state = r_reg.retState;
          r_next.memWrite = 1'b0;
          r_next.memAddr = r_reg.curDesc + `RDSW_OFS_W1;
        end
      end
      ST_STALL: begin
        rxReady = 1'b1;
        if (rxValid) begin
          r_next.missed = r_reg.missed + 1'b1;
          r_next.state = rxLast ? ST_IDLE : ST_DROP;
        end else if (pollHit || !r_reg.running) begin
          r_next.state = ST_IDLE;
        end
      end
      ST_DROP: begin
        rxReady = 1'b1;
        if (rxValid && rxLast) begin
          r_next.state = ST_IDLE;
        end
      end
      default: r_next.state = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_reg <= '0;
      r_reg.state <= ST_IDLE;
      r_reg.retState <= ST_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign regRdata = r_reg.rdData;
  assign txListBase = r_reg.txBase;
  assign memOut.req = (r_reg.state == ST_RD0) || (r_reg.state == ST_RD1) ||
                      (r_reg.state == ST_RD2) || (r_reg.state == ST_RD3) ||
                      (r_reg.state == ST_WR) || (r_reg.state == ST_CLOSE);
  assign memOut.write = r_reg.memWrite;
  assign memOut.addr = r_reg.memAddr;
  assign memOut.wdata = r_reg.memWdata;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence closeAck;
    r_reg.state == ST_CLOSE && memAck;
  endsequence
  sequence endClose;
    r_reg.state == ST_CLOSE && memOut.wdata[`RDSW_BIT_LAST] && !memOut.wdata[`RDSW_BIT_TRUNC];
  endsequence
  sequence lookAheadMiss;
    r_reg.state == ST_RD0 && memAck && !memRdata[`RDSW_BIT_OWN] && r_reg.inFrame;
  endsequence

  own_release_a: assert property (closeAck |-> memOut.write && !memOut.wdata[`RDSW_BIT_OWN])
    else $error("close write keeps ownership");
  list_start_a: assert property (regReq.wr && regReq.addr == `RDSW_REG_CTRL &&
      regReq.wdata[`RDSW_CTRL_RUN] && !r_reg.running |=> r_reg.curDesc == $past(r_reg.rxBase))
    else $error("walk does not start at list base");
  desc_words_a: assert property (r_reg.state == ST_RD1 && memAck |=>
      r_reg.state == ST_RD2 && memOut.addr == r_reg.curDesc + `RDSW_OFS_W2)
    else $error("descriptor word two fetched out of place");
  desc_link_a: assert property (r_reg.state == ST_RD2 && memAck |=>
      r_reg.state == ST_RD3 && memOut.addr == r_reg.curDesc + `RDSW_OFS_W3)
    else $error("descriptor word three fetched out of place");
  next_follow_a: assert property (r_reg.state == ST_WR && memAck && !r_reg.lastWord &&
      r_reg.segOff + `RDSW_WORD_BYTES >= {1'b0, r_reg.bufLen} |=>
      r_reg.state == ST_RD0 && memOut.addr == $past(r_reg.nextPtr))
    else $error("next descriptor pointer not followed");
  trunc_mark_a: assert property (lookAheadMiss |=> r_reg.state == ST_CLOSE &&
      memOut.wdata[`RDSW_BIT_TRUNC] && memOut.wdata[`RDSW_BIT_ERRSUM] &&
      memOut.addr == $past(r_reg.prevDesc))
    else $error("truncated frame not marked");
  len_field_a: assert property (endClose |->
      memOut.wdata[`RDSW_LEN_HI:`RDSW_LEN_LO] == r_reg.lastStat.byteCount)
    else $error("frame length field wrong");
  err_sum_a: assert property (endClose |-> memOut.wdata[`RDSW_BIT_ERRSUM] ==
      (memOut.wdata[`RDSW_BIT_SHORT] | memOut.wdata[`RDSW_BIT_LONG] |
      memOut.wdata[`RDSW_BIT_LATECOL] | memOut.wdata[`RDSW_BIT_CRC] |
      memOut.wdata[`RDSW_BIT_OVF]))
    else $error("error summary disagrees with flags");
  short_frame_a: assert property (endClose |-> memOut.wdata[`RDSW_BIT_SHORT] ==
      (r_reg.lastStat.byteCount < `RDSW_MIN_FRAME && !r_reg.lastStat.fifoOverflow))
    else $error("short frame flag wrong");
  long_frame_a: assert property (endClose |->
      memOut.wdata[`RDSW_BIT_LONG] == (r_reg.lastStat.byteCount > `RDSW_MAX_FRAME))
    else $error("overlong flag wrong");
  src_code_a: assert property (endClose and (!r_reg.csumEn) |->
      memOut.wdata[`RDSW_BIT_SRC_HI:`RDSW_BIT_SRC_LO] == r_reg.lastStat.loopSource)
    else $error("frame source code wrong");
  wdog_flag_a: assert property (r_reg.state == ST_WR && memAck && r_reg.lastWord &&
      !r_reg.csumEn && r_reg.lastStat.watchdogTimeout |=> r_reg.wdogFlag [*2])
    else $error("watchdog status bit not set");

endmodule

//--- shared/rdsw_defines.svh
// register offsets, descriptor bit positions and reset values of the rx writeback engine
`ifndef RDSW_DEFINES_SVH
`define RDSW_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RDSW_REG_CTRL 8'h00
`define RDSW_REG_RX_BASE 8'h18
`define RDSW_REG_TX_BASE 8'h20
`define RDSW_REG_INT_STAT 8'h28
`define RDSW_REG_MISSED 8'h40
`define RDSW_REG_CUR_DESC 8'h50
`define RDSW_REG_WD_CSUM 8'h78

// ----------------------------------------
// register fields and reset values
// ----------------------------------------
`define RDSW_CTRL_RUN 0
`define RDSW_CTRL_POLL 1
`define RDSW_INT_WDOG 9
`define RDSW_CSUM_EN 27
`define RDSW_RST_WORD 32'h0000_0000

// ----------------------------------------
// descriptor layout
// ----------------------------------------
`define RDSW_OFS_W1 32'h0000_0004
`define RDSW_OFS_W2 32'h0000_0008
`define RDSW_OFS_W3 32'h0000_000c
`define RDSW_WORD_BYTES 12'h004
`define RDSW_BLEN_HI 10
`define RDSW_BIT_OWN 31
`define RDSW_BIT_UNMATCH 30
`define RDSW_LEN_HI 29
`define RDSW_LEN_LO 16
`define RDSW_BIT_ERRSUM 15
`define RDSW_BIT_TRUNC 14
`define RDSW_BIT_SRC_HI 13
`define RDSW_BIT_SRC_LO 12
`define RDSW_BIT_SHORT 11
`define RDSW_BIT_MCAST 10
`define RDSW_BIT_FIRST 9
`define RDSW_BIT_LAST 8
`define RDSW_BIT_LONG 7
`define RDSW_BIT_LATECOL 6
`define RDSW_BIT_TYPE 5
`define RDSW_BIT_WDOG_TCP 4
`define RDSW_BIT_PHY_UDP 3
`define RDSW_BIT_ALIGN 2
`define RDSW_BIT_CRC 1
`define RDSW_BIT_OVF 0

// ----------------------------------------
// frame length limits
// ----------------------------------------
`define RDSW_MIN_FRAME 14'h0040
`define RDSW_MAX_FRAME 14'h05ee

`endif

//--- shared/rdsw_pkg.sv
// types shared by the rx descriptor writeback engine
package rdsw_pkg;

  typedef enum logic [9:0] {
    ST_IDLE  = 10'h001,
    ST_RD0   = 10'h002,
    ST_RD1   = 10'h004,
    ST_RD2   = 10'h008,
    ST_RD3   = 10'h010,
    ST_DATA  = 10'h020,
    ST_WR    = 10'h040,
    ST_CLOSE = 10'h080,
    ST_STALL = 10'h100,
    ST_DROP  = 10'h200
  } rdsw_state_t;

  typedef enum logic [2:0] {
    CL_MID   = 3'h1,
    CL_END   = 3'h2,
    CL_TRUNC = 3'h4
  } rdsw_close_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } rdsw_regreq_t;

  typedef struct packed {
    logic req;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } rdsw_memreq_t;

  typedef struct packed {
    logic [13:0] byteCount;
    logic addrUnmatched;
    logic multicastFlag;
    logic lateCollisionSeen;
    logic crcError;
    logic fifoOverflow;
    logic alignmentError;
    logic phyError;
    logic watchdogTimeout;
    logic [1:0] loopSource;
    logic ethType;
    logic ipPkt;
    logic tcpPkt;
    logic udpPkt;
    logic ipCsumFail;
    logic l4CsumFail;
  } rdsw_rxstat_t;

endpackage

//--- verif/rdsw_mem_model.sv
// host memory model answering the engine's bus-master requests
`timescale 1ns/1ps
module rdsw_mem_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input rdsw_pkg::rdsw_memreq_t memOut,
  input wire logic slow,
  output logic memAck,
  output logic [31:0] memRdata
);
  import rdsw_pkg::*;
  // ----------------------------------------
  // word store with fixed or slow answer
  // ----------------------------------------
  logic [31:0] mem [0:255];
  logic [1:0] waitCnt;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      memAck <= 1'b0;
      waitCnt <= 2'h0;
      memRdata <= 32'h0000_0000;
    end else if (memAck) begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
      if (memOut.write) begin
        mem[memOut.addr[9:2]] <= memOut.wdata;
      end
    end else if (memOut.req && waitCnt >= (slow ? 2'h3 : 2'h0)) begin
      memAck <= 1'b1;
      waitCnt <= 2'h0;
      memRdata <= mem[memOut.addr[9:2]];
    end else begin
      waitCnt <= memOut.req ? waitCnt + 2'h1 : 2'h0;
      memRdata <= ~memRdata;
    end
  end
endmodule

//--- verif/tb_rx_descriptor_status_writeback.sv
// self-checking bench of the rx descriptor writeback engine
`timescale 1ns/1ps
`include "rdsw_defines.svh"
module tb_rx_descriptor_status_writeback;
  import rdsw_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic rxValid = 1'b0;
  logic rxLast = 1'b0;
  logic slow = 1'b0;
  logic memAck, rxReady;
  logic [31:0] rxData = 32'h0000_0000;
  logic [31:0] regRdata, memRdata, txListBase, rv;
  rdsw_regreq_t regReq = '0;
  rdsw_memreq_t memOut;
  rdsw_rxstat_t st = '0;
  int numErrors = 0;
  int checksDone = 0;
  always #50 ref_clk = ~ref_clk;
  rdsw_core DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .regReq(regReq), .regRdata(regRdata),
    .memOut(memOut), .memAck(memAck), .memRdata(memRdata), .rxValid(rxValid),
    .rxData(rxData), .rxLast(rxLast), .rxStat(st), .rxReady(rxReady),
    .txListBase(txListBase));
  rdsw_mem_model mem0 (.ref_clk(ref_clk), .sys_rst(sys_rst), .memOut(memOut), .slow(slow),
    .memAck(memAck), .memRdata(memRdata));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      numErrors++;
    end
  endtask
  task automatic fail(input string nm);
    numErrors++;
    $display("[ERR] %s expected done seen timeout", nm);
    stop_test();
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regReq.addr <= a;
    regReq.wdata <= d;
    regReq.wr <= 1'b1;
    @(posedge ref_clk);
    regReq.wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    regReq.addr <= a;
    regReq.rd <= 1'b1;
    @(posedge ref_clk);
    regReq.rd <= 1'b0;
    @(negedge ref_clk);
    d = regRdata;
  endtask
  task automatic set_desc(input int w, input logic [31:0] bufAddr, input logic [10:0] len,
    input logic [31:0] nxt);
    mem0.mem[w] = 32'h8000_0000;
    mem0.mem[w+1] = {21'h002000, len};
    mem0.mem[w+2] = bufAddr;
    mem0.mem[w+3] = nxt;
  endtask
  task automatic send(input int n, input logic [31:0] base);
    for (int i = 0; i < n; i++) begin
      int k;
      @(posedge ref_clk);
      rxValid <= 1'b1;
      rxData <= base + i;
      rxLast <= (i == n - 1);
      k = 0;
      do begin
        @(negedge ref_clk);
        k++;
      end while (rxReady !== 1'b1 && k < 200);
      if (k >= 200) fail("rxReady");
    end
    @(posedge ref_clk);
    rxValid <= 1'b0;
    rxLast <= 1'b0;
  endtask
  task automatic wait_own(input int w);
    int k;
    for (k = 0; k < 300 && mem0.mem[w][31] !== 1'b0; k++) @(negedge ref_clk);
    if (k >= 300) fail("release");
    repeat (4) @(negedge ref_clk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    reg_rd(`RDSW_REG_RX_BASE, rv);
    check("rx base reset", rv, `RDSW_RST_WORD);
    reg_wr(`RDSW_REG_TX_BASE, 32'h0000_0c00);
    reg_rd(`RDSW_REG_TX_BASE, rv);
    check("tx base", rv, 32'h0000_0c00);
    check("tx base port", txListBase, 32'h0000_0c00);
    reg_rd(8'h04, rv);
    check("unmapped", rv, 32'h0000_0000);
    set_desc(16, 32'h0000_0100, 11'h040, 32'h0000_0080);
    set_desc(32, 32'h0000_0200, 11'h040, 32'h0000_0040);
    reg_wr(`RDSW_REG_RX_BASE, 32'h0000_0040);
    reg_wr(`RDSW_REG_CTRL, 32'h0000_0001);
    reg_rd(`RDSW_REG_CUR_DESC, rv);
    check("walk start", rv, 32'h0000_0040);
    $display("test regs done");
  endtask
  task automatic t_plain;
    st = '{byteCount: 14'd40, addrUnmatched: 1'b1, multicastFlag: 1'b1, crcError: 1'b1,
      phyError: 1'b1, watchdogTimeout: 1'b1, loopSource: 2'b10, ethType: 1'b1,
      l4CsumFail: 1'b1, default: 1'b0};
    send(2, 32'h1111_0000);
    wait_own(16);
    check("word0 plain", mem0.mem[16], 32'h4028_af3a);
    check("word0 plain", mem0.mem[16], 32'h4028_af3a);
    check("buffer data", mem0.mem[65], 32'h1111_0001);
    reg_rd(`RDSW_REG_INT_STAT, rv);
    check("watchdog status", rv, 32'h0000_0200);
    reg_wr(`RDSW_REG_INT_STAT, 32'h0000_0200);
    reg_rd(`RDSW_REG_INT_STAT, rv);
    check("status cleared", rv, 32'h0000_0000);
    reg_rd(`RDSW_REG_CUR_DESC, rv);
    check("next desc", rv, 32'h0000_0080);
    $display("test plain done");
  endtask
  task automatic t_csum;
    reg_wr(`RDSW_REG_WD_CSUM, 32'h0800_0000);
    slow <= 1'b1;
    st = '{byteCount: 14'd40, lateCollisionSeen: 1'b1, fifoOverflow: 1'b1,
      alignmentError: 1'b1, ipPkt: 1'b1, tcpPkt: 1'b1, ipCsumFail: 1'b1, loopSource: 2'b01,
      phyError: 1'b1, watchdogTimeout: 1'b1, default: 1'b0};
    send(2, 32'h2222_0000);
    wait_own(32);
    check("word0 csum", mem0.mem[32], 32'h0028_a375);
    check("word0 csum", mem0.mem[32], 32'h0028_a375);
    check("buffer data", mem0.mem[128], 32'h2222_0000);
    reg_rd(`RDSW_REG_INT_STAT, rv);
    check("no watchdog status", rv, 32'h0000_0000);
    reg_wr(`RDSW_REG_WD_CSUM, 32'h0000_0000);
    slow <= 1'b0;
    $display("test csum done");
  endtask
  task automatic t_multi;
    set_desc(16, 32'h0000_0100, 11'h008, 32'h0000_0080);
    set_desc(32, 32'h0000_0200, 11'h040, 32'h0000_0040);
    reg_wr(`RDSW_REG_CTRL, 32'h0000_0003);
    st = '{byteCount: 14'd1519, loopSource: 2'b11, default: 1'b0};
    send(3, 32'h4444_0000);
    wait_own(32);
    check("first segment", mem0.mem[16], 32'h0008_0200);
    check("last segment", mem0.mem[32], 32'h05ef_b180);
    check("second buffer", mem0.mem[128], 32'h4444_0002);
    $display("test multi done");
  endtask
  task automatic t_drop;
    send(1, 32'h5555_0000);
    repeat (4) @(negedge ref_clk);
    reg_rd(`RDSW_REG_MISSED, rv);
    check("missed count", rv, 32'h0000_0001);
    check("host word kept", mem0.mem[16], 32'h0008_0200);
    check("host buffer kept", mem0.mem[64], 32'h4444_0000);
    $display("test drop done");
  endtask
  task automatic t_trunc;
    set_desc(16, 32'h0000_0100, 11'h008, 32'h0000_0080);
    reg_wr(`RDSW_REG_CTRL, 32'h0000_0003);
    st = '0;
    send(3, 32'h6666_0000);
    wait_own(16);
    check("truncated segment", mem0.mem[16], 32'h0008_c300);
    check("no spill", mem0.mem[128], 32'h4444_0002);
    reg_rd(`RDSW_REG_MISSED, rv);
    check("missed after trunc", rv, 32'h0000_0001);
    $display("test trunc done");
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_plain();
    t_csum();
    t_multi();
    t_drop();
    t_trunc();
    stop_test();
  end
endmodule
